// File: src/timer_defs.svh
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_T0_LOW      8'h8a
`define ADDR_T1_LOW      8'h8b
`define ADDR_T0_HIGH     8'h8c
`define ADDR_T1_HIGH     8'h8d
`define ADDR_RATE_CTRL   8'h8e
`define ADDR_T2_CTRL     8'hc8
`define ADDR_CAP_LOW     8'hca
`define ADDR_CAP_HIGH    8'hcb
`define ADDR_T2_LOW      8'hcc
`define ADDR_T2_HIGH     8'hcd

// ----------------------------------------------------------------
// rate and wait control fields
// ----------------------------------------------------------------
`define RATE_T2_BIT      5
`define RATE_T1_BIT      4
`define RATE_T0_BIT      3
`define STRETCH_MSB      2
`define RATE_RESET       8'h01
`define RATE_USED_MASK   8'h3f
`define MOVX_BASE        4'h2

// ----------------------------------------------------------------
// timer two control fields
// ----------------------------------------------------------------
`define T2_OVF_BIT       7
`define T2_EXT_BIT       6
`define T2_RXCLK_BIT     5
`define T2_TXCLK_BIT     4
`define T2_EXTEN_BIT     3
`define T2_RUN_BIT       2
`define T2_SRC_BIT       1
`define T2_CAP_BIT       0
`define T2_CTRL_RESET    8'h00

// ----------------------------------------------------------------
// increment periods in core clocks
// ----------------------------------------------------------------
`define DIV_SLOW         4'd12
`define DIV_FAST         4'd4
`define DIV_BAUD         4'd2

`endif

// File: src/timer_pkg.sv
package timer_pkg;

    typedef enum logic [1:0] {
        MODE_13BIT,
        MODE_16BIT,
        MODE_8BIT_RELOAD,
        MODE_SPLIT
    } timer_mode_e;

    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
        logic       wrap;
    } timer_step_s;

endpackage

// File: src/pin_sync.sv
`timescale 1ns/100ps

module pin_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_q,
    output logic      [WIDTH-1:0] fall
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] level_d;
    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] prev_d;

    if (WIDTH < 1)
    begin : g_check
        $error("pin_sync needs at least one pin");
    end

    // ----------------------------------------------------------------
    // two-stage synchroniser and falling edge from later stages
    // ----------------------------------------------------------------
    always_comb
    begin
        meta_d  = pin_in;
        level_d = meta_q;
        prev_d  = level_q;
        fall    = prev_q & ~level_q;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_q  <= '1;
            level_q <= '1;
            prev_q  <= '1;
        end
        else
        begin
            meta_q  <= meta_d;
            level_q <= level_d;
            prev_q  <= prev_d;
        end
    end

endmodule

// File: src/clock_divider.sv
`timescale 1ns/100ps
`include "timer_defs.svh"

module clock_divider (
    input  wire logic clk,
    input  wire logic sys_rst,
    output logic      tick_baud,
    output logic      tick_fast,
    output logic      tick_slow
);

    logic [3:0] cnt_q;
    logic [3:0] cnt_d;

    // ----------------------------------------------------------------
    // one count of twelve gives every-2, every-4 and every-12 ticks
    // ----------------------------------------------------------------
    always_comb
    begin
        cnt_d     = (cnt_q == `DIV_SLOW - 4'd1) ? 4'd0 : cnt_q + 4'd1;
        tick_baud = ((cnt_q % `DIV_BAUD) == `DIV_BAUD - 4'd1);
        tick_fast = ((cnt_q % `DIV_FAST) == `DIV_FAST - 4'd1);
        tick_slow = (cnt_q == `DIV_SLOW - 4'd1);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cnt_q <= 4'd0;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

endmodule

// File: src/timer_block.sv
// Summary of operation
// - mode 0: 13-bit count from low byte bits 4:0 and whole high byte
// - timers 0/1 count clock or pin edges while run and gate condition allow
// - 13-bit wrap past 0x1fff sets flag and pulses output one cycle
// - mode 1: full 16-bit count wrapping after 0xffff, same flag and pulse
// - mode 2: low byte counts, reloads from high byte after 0xff
// - mode 3: timer 0 low byte is 8-bit counter on timer 0 controls
// - mode 3: timer 0 high byte counts divided clock, uses timer 1 run/flag
// - timer 1 in mode 3 stops and holds its count
// - with timer 0 split, timer 1 runs in modes 0-2, halts in mode 3
// - rate bits pick 4 or 12 clock increments, reset 0, ignored as counter
// - stretch field gives external move cycles of two plus field, reset 1
// - timer 2 overflow flag set past 0xffff only without baud selects
// - writing 1 to timer 2 flags sets them and raises the request
// - enabled falling edge on ext pin sets ext flag, also with baud selects
// - serial rx/tx clocks pick timer 2 or timer 1 overflow
// - ext edges ignored when disabled, trigger reload/capture unless baud
// - timer 2 runs only while its run bit is 1
// - timer 2 counts divided clock or input pin edges, baud base every 2
// - capture on ext edges, or reload on overflow and ext edges
// - any baud select forces reload after every overflow
// - capture copies count to capture registers, reload copies them back
// - baud overflow gives shift clock instead of flag, still reloads
`timescale 1ns/100ps
`include "timer_defs.svh"

module timer_block
    import timer_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic [1:0] timer_zero_mode,
    input  wire logic [1:0] timer_one_mode,
    input  wire logic       timer_zero_run,
    input  wire logic       timer_one_run,
    input  wire logic       timer_zero_count_source_select,
    input  wire logic       timer_one_count_source_select,
    input  wire logic       timer_zero_pin_hold_qualify,
    input  wire logic       timer_one_pin_hold_qualify,
    input  wire logic       timer_zero_input_pin,
    input  wire logic       timer_one_input_pin,
    input  wire logic       timer_two_input_pin,
    input  wire logic       timer_two_ext_pin,
    input  wire logic       ext_irq_zero_pin,
    input  wire logic       ext_irq_one_pin,
    output logic            timer_zero_pulse,
    output logic            timer_one_pulse,
    output logic            timer_zero_flag_set,
    output logic            timer_one_flag_set,
    output logic            timer_two_pulse,
    output logic            timer_two_irq,
    output logic            serial_rx_clock,
    output logic            serial_tx_clock,
    output logic      [3:0] movx_cycles
);

    // ----------------------------------------------------------------
    // pin synchronisers and increment ticks
    // ----------------------------------------------------------------
    logic [5:0] pin_level;
    logic [5:0] pin_fall;
    logic       tick_baud;
    logic       tick_fast;
    logic       tick_slow;

    pin_sync #(
        .WIDTH (6)
    ) u_pin_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin_in  ({ext_irq_one_pin, ext_irq_zero_pin, timer_two_ext_pin,
                   timer_two_input_pin, timer_one_input_pin, timer_zero_input_pin}),
        .level_q (pin_level),
        .fall    (pin_fall)
    );

    clock_divider u_clock_divider (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .tick_baud (tick_baud),
        .tick_fast (tick_fast),
        .tick_slow (tick_slow)
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]  t0_low_q,  t0_low_d;
    logic [7:0]  t0_high_q, t0_high_d;
    logic [7:0]  t1_low_q,  t1_low_d;
    logic [7:0]  t1_high_q, t1_high_d;
    logic [15:0] t2_cnt_q,  t2_cnt_d;
    logic [15:0] cap_q,     cap_d;
    logic [7:0]  rate_q,    rate_d;
    logic [7:0]  t2ctl_q,   t2ctl_d;
    logic [7:0]  rdata_d;
    logic        t0_pulse_d;
    logic        t1_pulse_d;
    logic        t0_flag_d;
    logic        t1_flag_d;
    logic        t2_pulse_d;
    logic        t2_irq_d;
    logic        rx_clk_d;
    logic        tx_clk_d;
    logic [3:0]  movx_d;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic timer_step_s step_timer(input logic [7:0] low,
                                               input logic [7:0] high,
                                               input timer_mode_e mode,
                                               input logic inc);
        timer_step_s r;
        r.low  = low;
        r.high = high;
        r.wrap = 1'b0;
        if (inc)
        begin
            unique case (mode)
                MODE_13BIT:
                begin
                    {r.wrap, r.high, r.low[4:0]} = {1'b0, high, low[4:0]} + 14'd1;
                end
                MODE_16BIT:
                begin
                    {r.wrap, r.high, r.low} = {1'b0, high, low} + 17'd1;
                end
                MODE_8BIT_RELOAD:
                begin
                    r.wrap = (low == 8'hff);
                    r.low  = r.wrap ? high : low + 8'd1;
                end
                MODE_SPLIT:
                begin
                    {r.wrap, r.low} = {1'b0, low} + 9'd1;
                end
            endcase
        end
        return r;
    endfunction

    function automatic logic rate_tick(input logic fast, input logic fs, input logic sl);
        return fast ? fs : sl;
    endfunction

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    timer_mode_e m0;
    timer_mode_e m1;
    timer_step_s s0;
    timer_step_s s1;
    logic        split0;
    logic        t0_inc;
    logic        t1_inc;
    logic        h0_inc;
    logic        h0_wrap;
    logic [7:0]  h0_next;
    logic        baud;
    logic        t2_inc;
    logic        t2_ovf;
    logic        ext_evt;
    logic        t2_ovf_set;
    logic        t2_ext_set;

    always_comb
    begin
        m0     = timer_mode_e'(timer_zero_mode);
        m1     = timer_mode_e'(timer_one_mode);
        split0 = (m0 == MODE_SPLIT);

        // timer zero
        t0_inc = timer_zero_run
               & (~timer_zero_pin_hold_qualify | pin_level[4])
               & (timer_zero_count_source_select ? pin_fall[0]
                  : rate_tick(rate_q[`RATE_T0_BIT], tick_fast, tick_slow));
        s0 = step_timer(t0_low_q, t0_high_q, m0, t0_inc);

        // split high byte, clock only, timer one run
        h0_inc = split0 & timer_one_run
               & rate_tick(rate_q[`RATE_T0_BIT], tick_fast, tick_slow);
        {h0_wrap, h0_next} = {1'b0, t0_high_q} + {8'd0, h0_inc};

        // timer one
        t1_inc = (split0 | timer_one_run) & (m1 != MODE_SPLIT)
               & (~timer_one_pin_hold_qualify | pin_level[5])
               & (timer_one_count_source_select ? pin_fall[1]
                  : rate_tick(rate_q[`RATE_T1_BIT], tick_fast, tick_slow));
        s1 = step_timer(t1_low_q, t1_high_q, m1, t1_inc);

        t0_low_d   = s0.low;
        t0_high_d  = split0 ? h0_next : s0.high;
        t1_low_d   = s1.low;
        t1_high_d  = s1.high;
        t0_pulse_d = s0.wrap;
        t0_flag_d  = s0.wrap;
        t1_pulse_d = s1.wrap;
        t1_flag_d  = split0 ? h0_wrap : s1.wrap;

        // timer two
        baud   = t2ctl_q[`T2_RXCLK_BIT] | t2ctl_q[`T2_TXCLK_BIT];
        t2_inc = t2ctl_q[`T2_RUN_BIT]
               & (t2ctl_q[`T2_SRC_BIT] ? pin_fall[2]
                  : (baud ? tick_baud
                     : rate_tick(rate_q[`RATE_T2_BIT], tick_fast, tick_slow)));
        t2_ovf  = t2_inc & (t2_cnt_q == 16'hffff);
        ext_evt = t2ctl_q[`T2_EXTEN_BIT] & pin_fall[3];
        t2_cnt_d = t2_cnt_q + {15'd0, t2_inc};
        cap_d    = cap_q;
        if (t2_ovf & (baud | ~t2ctl_q[`T2_CAP_BIT]))
        begin
            t2_cnt_d = cap_q;
        end
        if (ext_evt & ~baud)
        begin
            if (t2ctl_q[`T2_CAP_BIT])
            begin
                cap_d = t2_cnt_q;
            end
            else
            begin
                t2_cnt_d = cap_q;
            end
        end
        t2_ovf_set = t2_ovf & ~baud;
        t2_ext_set = ext_evt;
        t2_pulse_d = t2_ovf_set;
        rx_clk_d   = t2ctl_q[`T2_RXCLK_BIT] ? t2_ovf : s1.wrap;
        tx_clk_d   = t2ctl_q[`T2_TXCLK_BIT] ? t2_ovf : s1.wrap;

        rate_d  = rate_q;
        t2ctl_d = t2ctl_q;

        // software writes win over hardware counter and capture changes
        if (sfr_wr)
        begin
            unique case (sfr_addr)
                `ADDR_T0_LOW:    t0_low_d          = sfr_wdata;
                `ADDR_T0_HIGH:   t0_high_d         = sfr_wdata;
                `ADDR_T1_LOW:    t1_low_d          = sfr_wdata;
                `ADDR_T1_HIGH:   t1_high_d         = sfr_wdata;
                `ADDR_T2_LOW:    t2_cnt_d[7:0]     = sfr_wdata;
                `ADDR_T2_HIGH:   t2_cnt_d[15:8]    = sfr_wdata;
                `ADDR_CAP_LOW:   cap_d[7:0]        = sfr_wdata;
                `ADDR_CAP_HIGH:  cap_d[15:8]       = sfr_wdata;
                `ADDR_RATE_CTRL: rate_d            = sfr_wdata & `RATE_USED_MASK;
                `ADDR_T2_CTRL:   t2ctl_d           = sfr_wdata;
                default:         rate_d            = rate_q;
            endcase
        end

        // hardware sets win over software clears
        if (t2_ovf_set)
        begin
            t2ctl_d[`T2_OVF_BIT] = 1'b1;
        end
        if (t2_ext_set)
        begin
            t2ctl_d[`T2_EXT_BIT] = 1'b1;
        end
        t2_irq_d = t2ctl_d[`T2_OVF_BIT] | t2ctl_d[`T2_EXT_BIT];

        movx_d = `MOVX_BASE + {1'b0, rate_d[`STRETCH_MSB:0]};

        // read data, registered
        unique case (sfr_addr)
            `ADDR_T0_LOW:    rdata_d = t0_low_q;
            `ADDR_T0_HIGH:   rdata_d = t0_high_q;
            `ADDR_T1_LOW:    rdata_d = t1_low_q;
            `ADDR_T1_HIGH:   rdata_d = t1_high_q;
            `ADDR_T2_LOW:    rdata_d = t2_cnt_q[7:0];
            `ADDR_T2_HIGH:   rdata_d = t2_cnt_q[15:8];
            `ADDR_CAP_LOW:   rdata_d = cap_q[7:0];
            `ADDR_CAP_HIGH:  rdata_d = cap_q[15:8];
            `ADDR_RATE_CTRL: rdata_d = rate_q;
            `ADDR_T2_CTRL:   rdata_d = t2ctl_q;
            default:         rdata_d = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            t0_low_q            <= 8'h00;
            t0_high_q           <= 8'h00;
            t1_low_q            <= 8'h00;
            t1_high_q           <= 8'h00;
            t2_cnt_q            <= 16'h0000;
            cap_q               <= 16'h0000;
            rate_q              <= `RATE_RESET;
            t2ctl_q             <= `T2_CTRL_RESET;
            sfr_rdata           <= 8'h00;
            timer_zero_pulse    <= 1'b0;
            timer_one_pulse     <= 1'b0;
            timer_zero_flag_set <= 1'b0;
            timer_one_flag_set  <= 1'b0;
            timer_two_pulse     <= 1'b0;
            timer_two_irq       <= 1'b0;
            serial_rx_clock     <= 1'b0;
            serial_tx_clock     <= 1'b0;
            movx_cycles         <= `MOVX_BASE + 4'h1;
        end
        else
        begin
            t0_low_q            <= t0_low_d;
            t0_high_q           <= t0_high_d;
            t1_low_q            <= t1_low_d;
            t1_high_q           <= t1_high_d;
            t2_cnt_q            <= t2_cnt_d;
            cap_q               <= cap_d;
            rate_q              <= rate_d;
            t2ctl_q             <= t2ctl_d;
            sfr_rdata           <= rdata_d;
            timer_zero_pulse    <= t0_pulse_d;
            timer_one_pulse     <= t1_pulse_d;
            timer_zero_flag_set <= t0_flag_d;
            timer_one_flag_set  <= t1_flag_d;
            timer_two_pulse     <= t2_pulse_d;
            timer_two_irq       <= t2_irq_d;
            serial_rx_clock     <= rx_clk_d;
            serial_tx_clock     <= tx_clk_d;
            movx_cycles         <= movx_d;
        end
    end

endmodule

// File: verification/timer_block_props.sv
`timescale 1ns/100ps

module timer_block_props (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       timer_zero_run,
    input wire logic [1:0] timer_one_mode,
    input wire logic       timer_zero_pulse,
    input wire logic       timer_zero_flag_set,
    input wire logic       timer_one_pulse,
    input wire logic       timer_two_pulse,
    input wire logic       timer_two_irq,
    input wire logic [3:0] movx_cycles
);
    // ----------------------------------------------------------------
    // baud select shadow
    // ----------------------------------------------------------------
    logic baud_q;
    logic baud_d;

    always_comb
    begin
        baud_d = baud_q;
        if (sfr_wr && sfr_addr == 8'hc8)
            baud_d = |sfr_wdata[5:4];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            baud_q <= 1'b0;
        else
            baud_q <= baud_d;
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_rate_idle;
        (!(sfr_wr && sfr_addr == 8'h8e)) [*2];
    endsequence

    property p_rate_read;
        logic [7:0] v;
        (sfr_wr && sfr_addr == 8'h8e, v = sfr_wdata) ##1 (sfr_addr == 8'h8e && !sfr_wr)
            |=> sfr_rdata == (v & 8'h3f);
    endproperty
    a_rate_read: assert property (p_rate_read)
        else $error("rate register read back wrong");

    property p_movx;
        logic [2:0] s;
        (sfr_wr && sfr_addr == 8'h8e, s = sfr_wdata[2:0]) ##1 s_rate_idle
            |-> movx_cycles == 4'h2 + {1'b0, s};
    endproperty
    a_movx: assert property (p_movx)
        else $error("movx cycles not two plus field");

    property p_movx_rst;
        $fell(sys_rst) |-> movx_cycles == 4'h3;
    endproperty
    a_movx_rst: assert property (p_movx_rst)
        else $error("movx cycles not three after reset");

    property p_pulse_one;
        timer_zero_pulse |=> !timer_zero_pulse;
    endproperty
    a_pulse_one: assert property (p_pulse_one)
        else $error("timer zero pulse longer than one cycle");

    property p_flag_pulse;
        timer_zero_pulse |-> timer_zero_flag_set;
    endproperty
    a_flag_pulse: assert property (p_flag_pulse)
        else $error("timer zero wrap without flag set");

    property p_stop;
        (!timer_zero_run) [*3] |-> !timer_zero_pulse;
    endproperty
    a_stop: assert property (p_stop)
        else $error("timer zero wrapped while stopped");

    property p_t1_halt;
        (timer_one_mode == 2'h3) [*3] |-> !timer_one_pulse;
    endproperty
    a_t1_halt: assert property (p_t1_halt)
        else $error("timer one wrapped in mode 3");

    property p_baud_quiet;
        baud_q && $past(baud_q) |-> !timer_two_pulse;
    endproperty
    a_baud_quiet: assert property (p_baud_quiet)
        else $error("timer two overflow pulse in baud mode");

    property p_irq_sw;
        sfr_wr && sfr_addr == 8'hc8 && sfr_wdata[7] |-> ##[1:2] timer_two_irq;
    endproperty
    a_irq_sw: assert property (p_irq_sw)
        else $error("software flag set gave no request");
endmodule

bind timer_block timer_block_props i_props (.*);

// File: verification/timer_block_test.sv
`timescale 1ns/100ps

module timer_block_test;
    logic        clk;
    logic        sys_rst, sfr_wr;
    logic  [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic  [1:0] timer_zero_mode, timer_one_mode;
    logic        timer_zero_run, timer_one_run;
    logic        timer_zero_count_source_select, timer_one_count_source_select;
    logic        timer_zero_pin_hold_qualify, timer_one_pin_hold_qualify;
    logic        timer_zero_input_pin, timer_one_input_pin, timer_two_input_pin;
    logic        timer_two_ext_pin, ext_irq_zero_pin, ext_irq_one_pin;
    logic        timer_zero_pulse, timer_one_pulse, timer_zero_flag_set;
    logic        timer_one_flag_set, timer_two_pulse, timer_two_irq;
    logic        serial_rx_clock, serial_tx_clock;
    logic  [3:0] movx_cycles;
    logic  [6:0] ev;
    int          cnt [7];
    int          comparisons = 0;
    int          n_mismatch = 0;
    logic  [4:0] t1_cfg [5] = '{5'b01001, 5'b11001, 5'b11010, 5'b11011, 5'b11101};
    int          t1_exp [5] = '{4, 12, 0, 12, 0};
    logic [47:0] t0_tab [4] = '{48'h00_ff_ff_0b_00_01, 48'h00_1e_00_0a_01_00,
                                48'h01_fe_ff_0a_00_01, 48'h01_fe_00_0a_01_00};
    logic  [7:0] t2_init [4] = '{8'h34, 8'h12, 8'hfe, 8'hff};

    timer_block i_dut (.*);

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // ----------------------------------------------------------------
    // event counters
    // ----------------------------------------------------------------
    assign ev = {serial_rx_clock, serial_tx_clock, timer_two_pulse, timer_one_flag_set,
                 timer_zero_flag_set, timer_one_pulse, timer_zero_pulse};

    always @(posedge clk)
    begin
        foreach (cnt[i])
            cnt[i] += (ev[i] === 1'b1);
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        @(negedge clk);
        sfr_addr = a;
        @(negedge clk);
        chk(sfr_rdata & m, e);
    endtask

    task automatic measure(input int n);
        foreach (cnt[i])
            cnt[i] = 0;
        repeat (n) @(negedge clk);
    endtask

    task automatic window(input logic [1:0] runs);
        {timer_one_run, timer_zero_run} = runs;
        measure(48);
        {timer_one_run, timer_zero_run} = 2'b00;
        repeat (3) @(negedge clk);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        give_verdict;
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [47:0] e;
        {sys_rst, sfr_wr, sfr_addr, sfr_wdata} = {2'b10, 16'h0000};
        {timer_zero_mode, timer_one_mode, timer_zero_run, timer_one_run} = 6'h00;
        {timer_zero_count_source_select, timer_one_count_source_select} = 2'b00;
        {timer_zero_pin_hold_qualify, timer_one_pin_hold_qualify} = 2'b00;
        {timer_zero_input_pin, timer_one_input_pin, timer_two_input_pin} = 3'b111;
        {timer_two_ext_pin, ext_irq_zero_pin, ext_irq_one_pin} = 3'b111;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        rd(8'h8e, 8'h01);
        chk({4'h0, movx_cycles}, 8'h03);
        rd(8'hc8, 8'h00);
        wr(8'h8e, 8'hff);
        rd(8'h8e, 8'h3f);
        chk({4'h0, movx_cycles}, 8'h09);
        wr(8'h8d, 8'hff);
        wr(8'h8b, 8'hff);
        for (int k = 0; k < 5; k++)
        begin
            wr(8'h8e, {3'h0, t1_cfg[k][4], 4'h0});
            {timer_one_mode, timer_one_pin_hold_qualify, ext_irq_one_pin} = t1_cfg[k][3:0];
            repeat (4) @(negedge clk);
            window(2'b10);
            chk(8'(cnt[1]), 8'(t1_exp[k]));
            chk(8'(cnt[5]), 8'(t1_exp[k]));
            chk(8'(cnt[6]), 8'(t1_exp[k]));
        end
        {timer_one_mode, timer_one_count_source_select, timer_one_run} = 4'b1011;
        {timer_zero_count_source_select, timer_zero_run} = 2'b11;
        measure(0);
        repeat (5)
        begin
            {timer_zero_input_pin, timer_one_input_pin} = 2'b00;
            repeat (4) @(negedge clk);
            {timer_zero_input_pin, timer_one_input_pin} = 2'b11;
            repeat (4) @(negedge clk);
        end
        chk(8'(cnt[1]), 8'h05);
        rd(8'h8a, 8'h05, 8'h1f);
        {timer_zero_count_source_select, timer_zero_run} = 2'b00;
        {timer_one_mode, timer_one_count_source_select, timer_one_run} = 4'b1100;
        wr(8'h8e, 8'h08);
        for (int k = 0; k < 4; k++)
        begin
            e = t0_tab[k];
            timer_zero_mode = e[41:40];
            wr(8'h8a, e[39:32]);
            wr(8'h8c, e[31:24]);
            window(2'b01);
            chk(8'(cnt[0]), e[7:0]);
            chk(8'(cnt[2]), e[7:0]);
            rd(8'h8a, e[23:16], e[40] ? 8'hff : 8'h1f);
            rd(8'h8c, e[15:8]);
        end
        timer_zero_mode = 2'h3;
        wr(8'h8a, 8'hff);
        wr(8'h8c, 8'hff);
        window(2'b01);
        chk(8'(cnt[0]), 8'h01);
        chk(8'(cnt[3]), 8'h00);
        window(2'b10);
        chk(8'(cnt[3]), 8'h01);
        chk(8'(cnt[1]), 8'h00);
        rd(8'h8a, 8'h0b);
        rd(8'h8c, 8'h0b);
        timer_zero_mode = 2'h0;
        wr(8'h8e, 8'h20);
        for (int i = 0; i < 4; i++)
            wr(8'hca + 8'(i), t2_init[i]);
        wr(8'hc8, 8'h04);
        measure(40);
        chk(8'(cnt[4]), 8'h01);
        chk({7'h0, timer_two_irq}, 8'h01);
        rd(8'hcd, 8'h12);
        wr(8'hc8, 8'h09);
        wr(8'hcc, 8'h78);
        wr(8'hcd, 8'h56);
        timer_two_ext_pin = 1'b0;
        repeat (8) @(negedge clk);
        chk({7'h0, timer_two_irq}, 8'h01);
        rd(8'hca, 8'h78);
        rd(8'hcb, 8'h56);
        timer_two_ext_pin = 1'b1;
        wr(8'hc8, 8'h01);
        wr(8'hcc, 8'h9a);
        timer_two_ext_pin = 1'b0;
        repeat (8) @(negedge clk);
        chk({7'h0, timer_two_irq}, 8'h00);
        timer_two_ext_pin = 1'b1;
        rd(8'hca, 8'h78);
        wr(8'hc8, 8'h08);
        timer_two_ext_pin = 1'b0;
        repeat (8) @(negedge clk);
        rd(8'hcc, 8'h78);
        timer_two_ext_pin = 1'b1;
        wr(8'hc8, 8'h06);
        repeat (3)
        begin
            timer_two_input_pin = 1'b0;
            repeat (4) @(negedge clk);
            timer_two_input_pin = 1'b1;
            repeat (4) @(negedge clk);
        end
        rd(8'hcc, 8'h7b);
        for (int i = 0; i < 2; i++)
        begin
            wr(8'hc8, 8'h80 >> i);
            @(negedge clk);
            chk({7'h0, timer_two_irq}, 8'h01);
            wr(8'hc8, 8'h00);
            @(negedge clk);
            chk({7'h0, timer_two_irq}, 8'h00);
        end
        for (int i = 0; i < 4; i++)
            wr(8'hca + 8'(i), 8'hff);
        wr(8'hc8, 8'h25);
        measure(49);
        chk(8'(cnt[6]), 8'h18);
        chk(8'(cnt[5]), 8'h00);
        chk(8'(cnt[4]), 8'h00);
        chk({7'h0, timer_two_irq}, 8'h00);
        wr(8'hc8, 8'h00);
        give_verdict;
    end
endmodule
